// [src/acc_top.sv]
// Converter control: AXI4-Lite registers, start sequencing, clock divider, pin control
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module acc_top
	import acc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        core_done,
	input  wire logic [11:0] core_result,
	output acc_core_t        core_ctl,
	output acc_pins_t        pin_ctl,
	output logic             irq
);
	//////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0]  ctrl0_q, ctrl1_q, pinen_q, pullup_q, portdir_q;
	logic [11:0] result_q;
	logic        irq_st_q, irq_msk_q;
	acc_state_t  state_q;
	logic [4:0]  tick_cnt_q;
	logic        start_q;
	logic        done_ev;

	//////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path: address and data latched in either order
	logic       aw_have_q, w_have_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic       wr_go;
	logic       wr_lane0;
	logic [7:0] wr_byte;
	logic       wr_c0, wr_c1, wr_pe, wr_msk, wr_pu, wr_pd, wr_map;

	assign wr_go    = aw_have_q && w_have_q && !s_axi_bvalid;
	assign wr_lane0 = w_strb_q[0];
	assign wr_byte  = w_data_q[7:0];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= ACC_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign wr_c0  = wr_go && wr_lane0 && (aw_addr_q == ACC_OFF_CTRL0);
	assign wr_c1  = wr_go && wr_lane0 && (aw_addr_q == ACC_OFF_CTRL1);
	assign wr_pe  = wr_go && wr_lane0 && (aw_addr_q == ACC_OFF_PINEN);
	assign wr_msk = wr_go && wr_lane0 && (aw_addr_q == ACC_OFF_IRQMSK);
	assign wr_pu  = wr_go && wr_lane0 && (aw_addr_q == ACC_OFF_PULLUP);
	assign wr_pd  = wr_go && wr_lane0 && (aw_addr_q == ACC_OFF_PORTDIR);
	assign wr_map = (aw_addr_q[1:0] == 2'h0) && (aw_addr_q <= ACC_OFF_PORTDIR);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl0_q   <= ACC_CTRL0_RST;
			ctrl1_q   <= ACC_CTRL1_RST;
			pinen_q   <= ACC_PINEN_RST;
			pullup_q  <= ACC_PULLUP_RST;
			portdir_q <= ACC_PORTDIR_RST;
			irq_msk_q <= 1'b0;
		end else begin
			// Busy bit is read-only; its slot holds the live flag
			if (wr_c0) ctrl0_q <= wr_byte;
			if (wr_c1) ctrl1_q <= wr_byte & ACC_CTRL1_WMASK;
			if (wr_pe) pinen_q <= wr_byte;
			if (wr_msk) irq_msk_q <= wr_byte[0];
			if (wr_pu) pullup_q <= wr_byte;
			if (wr_pd) portdir_q <= wr_byte;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Start sequencing and conversion timing
	logic start_now, start_rise, start_fall, busy, tick;
	assign start_now  = ctrl0_q[ACC_CTRL0_START];
	assign start_rise = start_now && !start_q;
	assign start_fall = !start_now && start_q;
	assign busy       = (state_q != ACC_IDLE);

	acc_clkdiv u_div (
		.clk      (clk),
		.rst      (rst),
		.sync_clr (start_fall),
		.sel      (ctrl1_q[2:0]),
		.tick     (tick)
	);

	assign done_ev = (state_q == ACC_CONV) && tick && (tick_cnt_q == ACC_CONV_CYCLES - 5'h01);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q    <= ACC_IDLE;
			start_q    <= 1'b0;
			tick_cnt_q <= 5'h00;
		end else begin
			start_q <= start_now;
			unique case (state_q)
				ACC_IDLE: begin
					if (start_rise) state_q <= ACC_RESET;
				end
				ACC_RESET: begin
					if (start_fall) begin
						state_q    <= ACC_CONV;
						tick_cnt_q <= 5'h00;
					end
				end
				ACC_CONV: begin
					if (start_rise) begin
						state_q <= ACC_RESET;
					end else if (done_ev) begin
						state_q <= ACC_IDLE;
					end else if (tick) begin
						tick_cnt_q <= tick_cnt_q + 5'h01;
					end
				end
				default: state_q <= ACC_IDLE;
			endcase
		end
	end

	// Result latched at conversion end; set beats read-clear on the flag
	logic rd_st;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			result_q <= 12'h000;
			irq_st_q <= 1'b0;
			irq      <= 1'b0;
		end else begin
			if (done_ev) result_q <= core_result;
			if (done_ev && !start_rise) irq_st_q <= 1'b1;
			else if (rd_st) irq_st_q <= 1'b0;
			irq <= (irq_st_q || (done_ev && !start_rise)) && irq_msk_q && !(rd_st && !done_ev);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Outputs to core and pins
	logic [4:0] chan;
	assign chan = ctrl1_q[ACC_CTRL1_IREF] ? ACC_CHAN_BGAP : {1'b0, ctrl0_q[3:0]};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			core_ctl <= '0;
			pin_ctl  <= '0;
		end else begin
			core_ctl.power_en   <= !ctrl0_q[ACC_CTRL0_OFF];
			core_ctl.core_rst   <= (state_q != ACC_CONV);
			core_ctl.sample_clk <= tick && (state_q == ACC_CONV);
			core_ctl.ref_ext    <= ctrl1_q[ACC_CTRL1_VREF];
			core_ctl.channel    <= chan;
			pin_ctl.analog_en   <= pinen_q;
			pin_ctl.pullup_en   <= pullup_q & ~pinen_q;
			pin_ctl.dir_in      <= portdir_q | pinen_q;
			pin_ctl.vref_pin    <= ctrl1_q[ACC_CTRL1_VREF];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path
	logic [31:0] rd_mux;
	logic [11:0] res_al;
	logic        rd_go;
	assign res_al = ctrl0_q[ACC_CTRL0_ALIGN] ? result_q : 12'h000;
	assign rd_go  = s_axi_arvalid && s_axi_arready;
	assign rd_st  = rd_go && (s_axi_araddr == ACC_OFF_IRQST);

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (s_axi_araddr)
			ACC_OFF_CTRL0:   rd_mux = {24'h0, ctrl0_q[7], busy, ctrl0_q[5:0]};
			ACC_OFF_CTRL1:   rd_mux = {24'h0, ctrl1_q};
			ACC_OFF_PINEN:   rd_mux = {24'h0, pinen_q};
			ACC_OFF_RESULT:  rd_mux = ctrl0_q[ACC_CTRL0_ALIGN] ? {20'h0, res_al}
						: {16'h0, result_q, 4'h0};
			ACC_OFF_IRQST:   rd_mux = {31'h0, irq_st_q};
			ACC_OFF_IRQMSK:  rd_mux = {31'h0, irq_msk_q};
			ACC_OFF_PULLUP:  rd_mux = {24'h0, pullup_q};
			ACC_OFF_PORTDIR: rd_mux = {24'h0, portdir_q};
			default:         rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= ACC_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= ((s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= ACC_OFF_PORTDIR))
						? ACC_RESP_OKAY : ACC_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Checks
	a_start_resets: assert property (@(posedge clk) disable iff (rst)
		start_rise |=> state_q == ACC_RESET) else $error("start rise did not reset");
	a_fall_converts: assert property (@(posedge clk) disable iff (rst)
		(state_q == ACC_RESET && start_fall) |=> state_q == ACC_CONV)
		else $error("start fall did not start conversion");
	a_done_idle: assert property (@(posedge clk) disable iff (rst)
		(done_ev && !start_rise) |=> (state_q == ACC_IDLE && irq_st_q))
		else $error("conversion end not flagged");
	a_abort_noflag: assert property (@(posedge clk) disable iff (rst)
		(state_q == ACC_CONV && start_rise && !irq_st_q && !done_ev) |=> !irq_st_q)
		else $error("abort set the flag");
	a_irq_masked: assert property (@(posedge clk) disable iff (rst)
		!irq_msk_q |=> !irq) else $error("masked interrupt raised");
	a_power_follow: assert property (@(posedge clk) disable iff (rst)
		ctrl0_q[ACC_CTRL0_OFF] |=> !core_ctl.power_en) else $error("power not off");
	a_pullup_drop: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> (pin_ctl.pullup_en & $past(pinen_q)) == 8'h00)
		else $error("pull-up left on analog pin");
	a_dir_override: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> (pin_ctl.dir_in & $past(pinen_q)) == $past(pinen_q))
		else $error("analog pin not input");
	a_div_one: assert property (@(posedge clk) disable iff (rst)
		(ctrl1_q[2:0] == 3'h0 && !start_fall) |-> tick) else $error("undivided clock missed");
	// Start held high keeps the converter parked
	a_busy_hold: assert property (@(posedge clk) disable iff (rst)
		(start_q && start_now) |-> (busy && state_q == ACC_RESET))
		else $error("busy not held while start high");
	a_analog_follow: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> pin_ctl.analog_en == $past(pinen_q))
		else $error("analog enables not passed to pins");
	a_ref_follow: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> (core_ctl.ref_ext == $past(ctrl1_q[ACC_CTRL1_VREF])))
		else $error("reference select not followed");
	a_bgap_route: assert property (@(posedge clk) disable iff (rst)
		ctrl1_q[ACC_CTRL1_IREF] |=> core_ctl.channel == ACC_CHAN_BGAP)
		else $error("bandgap not routed");
endmodule
`default_nettype wire

// [src/acc_pkg.sv]
// Package for the converter control block: offsets, fields, reset values, types
package acc_pkg;

	localparam logic [7:0] ACC_OFF_CTRL0   = 8'h00;
	localparam logic [7:0] ACC_OFF_CTRL1   = 8'h04;
	localparam logic [7:0] ACC_OFF_PINEN   = 8'h08;
	localparam logic [7:0] ACC_OFF_RESULT  = 8'h0c;
	localparam logic [7:0] ACC_OFF_IRQST   = 8'h10;
	localparam logic [7:0] ACC_OFF_IRQMSK  = 8'h14;
	localparam logic [7:0] ACC_OFF_PULLUP  = 8'h18;
	localparam logic [7:0] ACC_OFF_PORTDIR = 8'h1c;

	localparam int ACC_CTRL0_START = 7;
	localparam int ACC_CTRL0_BUSY  = 6;
	localparam int ACC_CTRL0_OFF   = 5;
	localparam int ACC_CTRL0_ALIGN = 4;
	localparam int ACC_CTRL1_IREF  = 7;
	localparam int ACC_CTRL1_BGEN  = 6;
	localparam int ACC_CTRL1_VREF  = 4;

	localparam logic [7:0] ACC_CTRL0_RST   = 8'h60;
	localparam logic [7:0] ACC_CTRL1_RST   = 8'h00;
	localparam logic [7:0] ACC_PINEN_RST   = 8'hff;
	localparam logic [7:0] ACC_PULLUP_RST  = 8'h00;
	localparam logic [7:0] ACC_PORTDIR_RST = 8'hff;
	localparam logic [7:0] ACC_CTRL1_WMASK = 8'hd7;

	localparam logic [2:0] ACC_DIV_UNDEF   = 3'h7;
	localparam logic [4:0] ACC_CONV_CYCLES = 5'h10;
	localparam logic [4:0] ACC_CHAN_BGAP   = 5'h10;
	localparam logic [1:0] ACC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ACC_IDLE  = 2'b00,
		ACC_RESET = 2'b01,
		ACC_CONV  = 2'b10
	} acc_state_t;

	typedef struct packed {
		logic        power_en;
		logic        core_rst;
		logic        sample_clk;
		logic        ref_ext;
		logic [4:0]  channel;
	} acc_core_t;

	typedef struct packed {
		logic [7:0] analog_en;
		logic [7:0] pullup_en;
		logic [7:0] dir_in;
		logic       vref_pin;
	} acc_pins_t;

endpackage

// [src/acc_clkdiv.sv]
// Converter clock divider: one-cycle enable pulse per converter clock period
`timescale 1ns/1ps
`default_nettype none
module acc_clkdiv
	import acc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       sync_clr,
	input  wire logic [2:0] sel,
	output logic            tick
);
	logic [5:0] cnt_q;
	logic [5:0] limit;
	logic       hit;

	// Code 000 ticks every cycle; undefined code treated as slowest
	assign limit = (sel == ACC_DIV_UNDEF) ? 6'h3f : 6'((7'h01 << sel) - 7'h01);
	assign hit   = (cnt_q >= limit);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 6'h00;
		end else if (sync_clr || hit) begin
			cnt_q <= 6'h00;
		end else begin
			cnt_q <= cnt_q + 6'h01;
		end
	end

	assign tick = hit && !sync_clr;
endmodule
`default_nettype wire

// [dv/acc_core_model.sv]
// Behavioural converter core: returns a channel-coded result
`timescale 1ns/1ps
`default_nettype none
module acc_core_model
	import acc_pkg::*;
(
	input  wire logic      clk,
	input  wire acc_core_t ctl,
	output logic           done,
	output logic [11:0]    result
);
	logic [11:0] junk_q = 12'h000;
	// Completion timing lives in the block, so done stays low
	assign done = 1'b0;
	// Unpowered core shows junk_q, which negates itself each cycle and so stays at zero
	assign result = ctl.power_en ? {3'h5, ctl.channel, 4'hc} : junk_q;
	always_ff @(posedge clk) begin
		junk_q <= ~junk_q + 12'h001;
	end
endmodule
`default_nettype wire

// [dv/acc_top_tb.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acc_top_tb
	import acc_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'h1;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        core_done;
	logic [11:0] core_result;
	acc_core_t   core_ctl;
	acc_pins_t   pin_ctl;
	logic        irq;
	logic [31:0] rv;
	logic [1:0]  rr;
	int          fails = 0, cmp_count = 0, cyc = 0, ticks = 0, gap = 0, last_gap = 0;
	int          tick_base = 0;

	acc_top i_acc_top (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_done,
		.core_result, .core_ctl, .pin_ctl, .irq);
	acc_core_model i_acc_core_model (.clk, .ctl(core_ctl), .done(core_done),
		.result(core_result));

	always #20 clk = ~clk;
	//////////////////////////////////////////////////////////////////////////////
	// Tick spacing and count, plus the hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		gap <= gap + 1;
		if (core_ctl.sample_clk) begin
			ticks <= ticks + 1;
			last_gap <= gap + 1;
			gap <= 0;
		end
		if (cyc == 30000) begin
			fails++;
			complete_run;
		end
	end
	//////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", 32'(ACC_RESP_OKAY), 32'(s_axi_bresp));
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		rv = s_axi_rdata;
		rr = s_axi_rresp;
	endtask

	task automatic wait_idle;
		do rd(ACC_OFF_CTRL0);
		while (rv[ACC_CTRL0_BUSY] !== 1'b0);
	endtask

	task automatic conv(input logic [2:0] sel, input logic al);
		wr(ACC_OFF_CTRL1, {29'h0, sel});
		wr(ACC_OFF_CTRL0, {24'h0, 3'b100, al, 4'h3});
		rd(ACC_OFF_CTRL0);
		chk("busy_hold", 32'h1, 32'(rv[ACC_CTRL0_BUSY]));
		chk("core_rst", 32'h1, 32'(core_ctl.core_rst));
		tick_base = ticks;
		wr(ACC_OFF_CTRL0, {24'h0, 3'b000, al, 4'h3});
		wait_idle;
		chk("ticks", 32'd16, 32'(ticks - tick_base));
		chk("tick_gap", 32'd1 << sel, 32'(last_gap));
		rd(ACC_OFF_RESULT);
		chk("result", al ? 32'h0a3c : 32'ha3c0, rv);
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk("analog_en", 32'hff, 32'(pin_ctl.analog_en));
		chk("dir_in", 32'hff, 32'(pin_ctl.dir_in));
		chk("power_en", 32'h0, 32'(core_ctl.power_en));
		rd(ACC_OFF_PINEN);
		chk("pinen_rst", 32'hff, rv);
		rd(ACC_OFF_CTRL0);
		chk("ctrl0_rst", 32'h20, rv);
		$display("test reset done");
	endtask

	task automatic t_pins;
		wr(ACC_OFF_PULLUP, 32'hff);
		wr(ACC_OFF_PORTDIR, 32'h00);
		wr(ACC_OFF_PINEN, 32'h0f);
		wr(ACC_OFF_CTRL1, 32'h10);
		repeat (2) @(posedge clk);
		chk("pullup_en", 32'hf0, 32'(pin_ctl.pullup_en));
		chk("dir_in", 32'h0f, 32'(pin_ctl.dir_in));
		chk("analog_en", 32'h0f, 32'(pin_ctl.analog_en));
		chk("vref_pin", 32'h1, 32'(pin_ctl.vref_pin));
		chk("ref_ext", 32'h1, 32'(core_ctl.ref_ext));
		wr(ACC_OFF_CTRL1, 32'h00);
		repeat (2) @(posedge clk);
		chk("ref_ext", 32'h0, 32'(core_ctl.ref_ext));
		$display("test pins done");
	endtask

	task automatic t_conv;
		wr(ACC_OFF_IRQMSK, 32'h1);
		wr(ACC_OFF_CTRL0, 32'h03);
		// Settling time for the analog section before any start
		repeat (20) @(posedge clk);
		chk("power_en", 32'h1, 32'(core_ctl.power_en));
		for (int s = 0; s < 7; s++) begin
			conv(s[2:0], s[0]);
			chk("irq", 32'h1, 32'(irq));
			rd(ACC_OFF_IRQST);
			chk("status", 32'h1, rv);
			repeat (2) @(posedge clk);
			chk("irq_clr", 32'h0, 32'(irq));
		end
		wr(ACC_OFF_IRQMSK, 32'h0);
		conv(3'h1, 1'b0);
		chk("irq_masked", 32'h0, 32'(irq));
		rd(ACC_OFF_IRQST);
		chk("status_masked", 32'h1, rv);
		$display("test conversions done");
	endtask

	task automatic t_abort;
		// Divide by 16 keeps the converter period in its legal band
		wr(ACC_OFF_CTRL1, 32'h04);
		wr(ACC_OFF_CTRL0, 32'h83);
		wr(ACC_OFF_CTRL0, 32'h03);
		repeat (6) @(posedge clk);
		wr(ACC_OFF_CTRL0, 32'h83);
		rd(ACC_OFF_CTRL0);
		chk("abort_busy", 32'h1, 32'(rv[ACC_CTRL0_BUSY]));
		rd(ACC_OFF_IRQST);
		chk("abort_status", 32'h0, rv);
		tick_base = ticks;
		wr(ACC_OFF_CTRL0, 32'h03);
		wait_idle;
		chk("restart_ticks", 32'd16, 32'(ticks - tick_base));
		rd(ACC_OFF_IRQST);
		chk("restart_status", 32'h1, rv);
		$display("test abort done");
	endtask

	task automatic t_chan;
		for (int c = 0; c < 16; c++) begin
			wr(ACC_OFF_CTRL0, 32'(c));
			repeat (2) @(posedge clk);
			chk("channel", 32'(c), 32'(core_ctl.channel));
		end
		wr(ACC_OFF_CTRL1, 32'hc0);
		repeat (2) @(posedge clk);
		chk("bandgap", 32'(ACC_CHAN_BGAP), 32'(core_ctl.channel));
		wr(ACC_OFF_CTRL1, 32'h00);
		$display("test channels done");
	endtask

	task automatic t_bus;
		rd(8'h20);
		chk("unmapped_resp", 32'(ACC_RESP_SLVERR), 32'(rr));
		chk("unmapped_data", 32'h0, rv);
		wr(ACC_OFF_CTRL0, 32'h20);
		repeat (2) @(posedge clk);
		chk("power_off", 32'h0, 32'(core_ctl.power_en));
		$display("test bus done");
	endtask
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_reset;
		t_pins;
		t_conv;
		t_abort;
		t_chan;
		t_bus;
		complete_run;
	end
endmodule
`default_nettype wire
